// File: bench/hbs_host_model.sv
// Purpose: host side of the brake sequencer
// Assumes: relay contact follows the brake output
// Notes:   motion held back 5 steps after release
`timescale 1ns/1ns
module hbs_host_model #(parameter int STEP_CYCLES = 10) (
  // clock and brake line
  input wire logic clk,
  input wire logic brake_release_out,
  // motion allowed
  output logic     ref_ok
);
  int t;
  // saturates so long runs never wrap
  always_ff @(posedge clk) t <= !brake_release_out ? 0 : t + int'(t < 5 * STEP_CYCLES);
  assign ref_ok = t >= 5 * STEP_CYCLES;
endmodule : hbs_host_model

// File: bench/hbs_sequencer_monitor.sv
// Purpose: port checks for the brake sequencer
// Assumes: short step count in sim
// Notes:   bound after the module
`timescale 1ns/1ns
`include "hbs_defs.svh"
module hbs_chk #(
  parameter int STEP_CYCLES = 10,
  parameter int NUM_TERMS   = 3,
  parameter int SPEED_W     = 16
) (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst,
  // sequence inputs
  input wire logic                 servo_on,
  input wire logic                 alarm,
  input wire logic                 zero_speed_alarm,
  input wire logic                 overtravel,
  input wire logic                 motor_stopped,
  input wire logic [SPEED_W-1:0]   motor_speed,
  input wire logic [13:0]          motor_max_speed,
  // settings
  input wire hbs_pkg::hbs_cfg_t    cfg,
  input wire logic [NUM_TERMS-1:0] other_func_out,
  // outputs
  input wire logic [NUM_TERMS-1:0] term_out,
  input wire logic                 brake_release_out,
  input wire logic                 motor_power_on
);
  logic [SPEED_W-1:0] spd;
  logic [13:0]        lvl_cap;
  logic [13:0]        lvl;
  assign spd = motor_speed[SPEED_W-1] ? SPEED_W'(-motor_speed) : motor_speed;
  // level capped at the setting ceiling, then at what the motor can reach
  assign lvl_cap = cfg.brake_speed_level > `HBS_SPEED_LEVEL_MAX ?
                   `HBS_SPEED_LEVEL_MAX : cfg.brake_speed_level;
  assign lvl = lvl_cap > motor_max_speed ? motor_max_speed : lvl_cap;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_alarm; alarm && motor_stopped && !overtravel |=> !brake_release_out; endproperty
  a_alarm: assert property (p_alarm) else $error("brake held on alarm");
  property p_ot; overtravel |=> brake_release_out; endproperty
  a_ot: assert property (p_ot) else $error("brake set in overtravel");
  property p_map; $onehot0(term_out & ~$past(other_func_out)); endproperty
  a_map: assert property (p_map) else $error("brake on two terminals");
  // terminals restart from zero, so the edge after reset is skipped
  property p_or; !brake_release_out && !$past(rst) |-> term_out == $past(other_func_out);
  endproperty
  a_or: assert property (p_or) else $error("terminal not an OR");
  property p_stop; $fell(servo_on) && motor_stopped && !overtravel
    |=> !brake_release_out; endproperty
  a_stop: assert property (p_stop) else $error("brake late at stop");
  property p_dly; $fell(servo_on) && motor_stopped && motor_power_on && !alarm &&
    cfg.stopped_brake_delay == 6'h01 |=> motor_power_on [*8] ##[1:4] !motor_power_on;
  endproperty
  a_dly: assert property (p_dly) else $error("power delay wrong");
  property p_pwr; alarm && (motor_stopped || !zero_speed_alarm) |=> !motor_power_on; endproperty
  a_pwr: assert property (p_pwr) else $error("power kept on alarm");
  property p_slow; brake_release_out && !motor_power_on && !overtravel && spd < lvl
    |=> !brake_release_out; endproperty
  a_slow: assert property (p_slow) else $error("brake late at low speed");
endmodule : hbs_chk

bind hbs_sequencer hbs_chk #(
  .STEP_CYCLES (STEP_CYCLES),
  .NUM_TERMS   (NUM_TERMS),
  .SPEED_W     (SPEED_W)
) i_chk (
  .clk               (clk),
  .rst               (rst),
  .servo_on          (servo_on),
  .alarm             (alarm),
  .zero_speed_alarm  (zero_speed_alarm),
  .overtravel        (overtravel),
  .motor_stopped     (motor_stopped),
  .motor_speed       (motor_speed),
  .motor_max_speed   (motor_max_speed),
  .cfg               (cfg),
  .other_func_out    (other_func_out),
  .term_out          (term_out),
  .brake_release_out (brake_release_out),
  .motor_power_on    (motor_power_on)
);

// File: bench/hbs_sequencer_tb.sv
// Purpose: directed test of the brake sequencer
// Assumes: step cut to 10 cycles
// Notes:   host model gates motion after release
`timescale 1ns/1ns
module hbs_sequencer_tb;
  logic clk = 1'h0;
  logic rst, servo_on, alarm, zsa, ot, stopped, rel, pwr, ref_ok;
  logic [15:0] speed;
  logic [13:0] max_spd;
  logic [2:0] other, term;
  logic [1:0] alloc;
  hbs_pkg::hbs_cfg_t cfg;
  int mismatches, check_count;
  hbs_sequencer #(.STEP_CYCLES(10)) i_dut (.clk(clk), .rst(rst), .servo_on(servo_on),
    .alarm(alarm), .zero_speed_alarm(zsa), .overtravel(ot), .motor_stopped(stopped),
    .motor_speed(speed), .motor_max_speed(max_spd), .cfg(cfg), .output_alloc_setting(alloc),
    .other_func_out(other), .brake_release_out(rel), .motor_power_on(pwr), .term_out(term));
  hbs_host_model #(.STEP_CYCLES(10)) i_host (.clk(clk), .brake_release_out(rel),
    .ref_ok(ref_ok));
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic go_on;
    $display("test segment done");
    tick(1);
    servo_on <= 1'h1;
    for (int i = 0; i < 99 && ref_ok !== 1'h1; i++) tick(1);
  endtask : go_on
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  initial forever #5 clk = ~clk;
  initial begin
    #20000 mismatches++;
    print_verdict();
  end
  initial begin
    {rst, stopped, servo_on, alarm, zsa, ot} = 6'h30;
    {speed, max_spd, alloc, other} = {16'h0000, 14'h0064, 2'h2, 3'h0};
    cfg = '{6'h01, 7'h05, 14'h2710};
    tick(3);
    rst <= 1'h0;
    tick(2);
    {alloc, other, servo_on} <= {2'h3, 3'h1, 1'h1};
    #1 chk("idle", 5'h00, {rel, pwr, term});
    tick(1);
    servo_on <= 1'h0;
    #1 chk("run", 5'h1B, {rel, pwr, term});
    tick(1);
    #1 chk("stop", 5'h09, {rel, pwr, term});
    tick(9);
    #1 chk("held", 5'h01, pwr);
    tick(1);
    #1 chk("delay", 5'h00, pwr);
    tick(1);
    cfg.stopped_brake_delay <= 6'h05;
    go_on();
    alarm <= 1'h1;
    tick(1);
    {alarm, servo_on} <= 2'h0;
    #1 chk("alarm", 5'h00, {rel, pwr});
    go_on();
    {stopped, speed} <= {1'h0, 16'hFE0C};
    tick(2);
    servo_on <= 1'h0;
    tick(1);
    #1 chk("coast", 5'h02, {rel, pwr});
    tick(20);
    speed <= 16'hFFCE;
    #1 chk("clip", 5'h01, rel);
    tick(1);
    #1 chk("slow", 5'h00, rel);
    go_on();
    speed <= 16'h01F4;
    tick(1);
    servo_on <= 1'h0;
    tick(100);
    #1 chk("wait", 5'h01, rel);
    tick(1);
    ot <= 1'h1;
    #1 chk("waited", 5'h00, rel);
    tick(1);
    ot <= 1'h0;
    rst <= 1'h1;
    #1 chk("ot", 5'h01, rel);
    tick(2);
    rst <= 1'h0;
    #1 chk("reset", 5'h00, {rel, pwr, term});
    go_on();
    #1 chk("realloc", 5'h1D, {rel, pwr, term});
    {alarm, zsa} <= 2'h3;
    tick(5);
    #1 chk("zero", 5'h03, {rel, pwr});
    stopped <= 1'h1;
    tick(1);
    #1 chk("rest", 5'h00, {rel, pwr});
    $display("test segment done");
    print_verdict();
  end
endmodule : hbs_sequencer_tb

// File: core/hbs_defs.svh
// Purpose: constants for the holding brake sequencer
// Assumes: 100 MHz control clock
// Notes:   times in ms, counts derived from the clock rate
`ifndef HBS_DEFS_SVH
`define HBS_DEFS_SVH

`define HBS_CLK_MHZ          100
`define HBS_STEP_MS          10
`define HBS_STEP_CYCLES      (`HBS_STEP_MS * 1000 * `HBS_CLK_MHZ)
`define HBS_STOP_DELAY_MAX   6'h32
`define HBS_STOP_DELAY_RST   6'h00
`define HBS_MOVE_WAIT_MIN    7'h0A
`define HBS_MOVE_WAIT_MAX    7'h64
`define HBS_MOVE_WAIT_RST    7'h32
`define HBS_SPEED_LEVEL_MAX  14'h2710
`define HBS_SPEED_LEVEL_RST  14'h000A
`define HBS_ALLOC_NONE       2'h0
`define HBS_NUM_TERMS        3

`endif

// File: core/hbs_out_map.sv
// Purpose: places the brake signal on an output terminal pair
// Assumes: allocation latched once after reset
// Notes:   shared terminals are ORed with other functions
`timescale 1ns/1ns
`include "hbs_defs.svh"

module hbs_out_map #(
  parameter int NUM_TERMS = `HBS_NUM_TERMS
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // brake and other functions
  input  wire logic                 brake_release,
  input  wire logic [1:0]           alloc,
  input  wire logic [NUM_TERMS-1:0] other_func_out,
  // terminals
  output logic      [NUM_TERMS-1:0] term_out
);

  genvar g;
  generate
    for (g = 0; g < NUM_TERMS; g++) begin : g_term
      wire sel = (alloc == 2'(g + 1));
      always_ff @(posedge clk) begin
        if (rst) begin
          term_out[g] <= 1'b0;
        end else begin
          term_out[g] <= (sel & brake_release) | other_func_out[g];
        end
      end
    end
  endgenerate

endmodule : hbs_out_map

// File: core/hbs_pkg.sv
// Purpose: types for the holding brake sequencer
// Assumes: nothing
// Notes:   settings travel as one packed struct
package hbs_pkg;

  typedef struct packed {
    logic [5:0]  stopped_brake_delay;
    logic [6:0]  moving_brake_wait;
    logic [13:0] brake_speed_level;
  } hbs_cfg_t;

  typedef enum logic [2:0] {
    ST_OFF, ST_ON, ST_STOP_DELAY, ST_MOVE_WAIT
  } hbs_state_t;

endpackage : hbs_pkg

// File: core/hbs_sequencer.sv
// Purpose: holding brake release and motor power sequencing
// Assumes: settings and speed synchronous to clk, speed signed mm/s
// Notes:   the terminal allocation is taken once, one cycle after reset
`timescale 1ns/1ns
`include "hbs_defs.svh"

module hbs_sequencer #(
  parameter int STEP_CYCLES = `HBS_STEP_CYCLES,
  parameter int NUM_TERMS   = `HBS_NUM_TERMS,
  parameter int SPEED_W     = 16
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // sequence inputs
  input  wire logic                 servo_on,
  input  wire logic                 alarm,
  input  wire logic                 zero_speed_alarm,
  input  wire logic                 overtravel,
  input  wire logic                 motor_stopped,
  input  wire logic [SPEED_W-1:0]   motor_speed,
  input  wire logic [13:0]          motor_max_speed,
  // settings
  input  wire hbs_pkg::hbs_cfg_t    cfg,
  input  wire logic [1:0]           output_alloc_setting,
  input  wire logic [NUM_TERMS-1:0] other_func_out,
  // outputs
  output logic                      brake_release_out,
  output logic                      motor_power_on,
  output logic [NUM_TERMS-1:0]      term_out
);

  ////////////////////////////////////////////////////////////////////////////
  // settings and speed

  hbs_pkg::hbs_state_t state_reg, state_next;
  logic [1:0]  alloc_reg;
  logic        alloc_taken_reg;
  logic [31:0] tick_reg;
  logic [6:0]  steps_reg;

  // one clamp serves every setting; narrower fields are widened first
  function automatic logic [13:0] clamp14(input logic [13:0] val,
                                          input logic [13:0] lo,
                                          input logic [13:0] hi);
    logic [13:0] res;
    res = val;
    if (val < lo) begin
      res = lo;
    end
    if (res > hi) begin
      res = hi;
    end
    return res;
  endfunction : clamp14

  // a timer ends on the last tick of the step that reaches its target
  function automatic logic steps_reached(input logic       tick_end,
                                         input logic [6:0] steps,
                                         input logic [6:0] target);
    return tick_end && (steps + 7'h01 >= target);
  endfunction : steps_reached

  wire [13:0]        delay_wide;
  wire [5:0]         delay_steps;
  wire [13:0]        wait_wide;
  wire [6:0]         wait_steps;
  wire [13:0]        lvl_lim;
  wire [13:0]        lvl_eff;
  wire [SPEED_W-1:0] speed_abs;
  wire               below_level;
  wire               step_done;
  wire               stop_req;
  wire               at_rest;
  wire               delay_over;
  wire               wait_over;

  // out-of-range settings are clamped so the timers stay bounded
  assign delay_wide  = clamp14(14'(cfg.stopped_brake_delay), 14'h0000,
                               14'(`HBS_STOP_DELAY_MAX));
  assign delay_steps = delay_wide[5:0];
  assign wait_wide   = clamp14(14'(cfg.moving_brake_wait), 14'(`HBS_MOVE_WAIT_MIN),
                               14'(`HBS_MOVE_WAIT_MAX));
  assign wait_steps  = wait_wide[6:0];
  assign lvl_lim     = clamp14(cfg.brake_speed_level, 14'h0000, `HBS_SPEED_LEVEL_MAX);
  assign lvl_eff     = clamp14(lvl_lim, 14'h0000, motor_max_speed);
  // direction of travel does not matter for the level test
  assign speed_abs   = motor_speed[SPEED_W-1] ?
                       SPEED_W'(-motor_speed) : motor_speed;
  assign below_level = speed_abs < SPEED_W'(lvl_eff);

  assign step_done   = (tick_reg == 32'(STEP_CYCLES - 1));
  assign stop_req    = alarm | ~servo_on;
  // zero-speed stop alarm behaves as stationary once at rest
  assign at_rest     = motor_stopped;
  assign delay_over  = steps_reached(step_done, steps_reg, 7'(delay_steps));
  assign wait_over   = steps_reached(step_done, steps_reg, wait_steps);

  ////////////////////////////////////////////////////////////////////////////
  // state sequencing

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hbs_pkg::ST_OFF: begin
        if (servo_on && !alarm) begin
          state_next = hbs_pkg::ST_ON;
        end
      end
      hbs_pkg::ST_ON: begin
        if (stop_req && at_rest) begin
          if (alarm || delay_steps == 6'h00) begin
            state_next = hbs_pkg::ST_OFF;
          end else begin
            state_next = hbs_pkg::ST_STOP_DELAY;
          end
        end else if (stop_req && !(alarm && zero_speed_alarm)) begin
          state_next = hbs_pkg::ST_MOVE_WAIT;
        end
      end
      hbs_pkg::ST_STOP_DELAY: begin
        if (alarm || delay_over) begin
          state_next = hbs_pkg::ST_OFF;
        end
      end
      hbs_pkg::ST_MOVE_WAIT: begin
        if (below_level || wait_over) begin
          state_next = hbs_pkg::ST_OFF;
        end
      end
      default: state_next = hbs_pkg::ST_OFF;
    endcase
  end

  // power stays on only while energised states hold
  wire power_next = (state_next == hbs_pkg::ST_ON) ||
                    (state_next == hbs_pkg::ST_STOP_DELAY);
  // brake applied the cycle servo-on drops when at rest, unless overtravel holds it released
  wire release_next = overtravel ? 1'b1 :
                      (state_next == hbs_pkg::ST_ON) ||
                      (state_next == hbs_pkg::ST_MOVE_WAIT);

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= hbs_pkg::ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step timers, restarted on every state change

  always_ff @(posedge clk) begin
    if (rst || state_next != state_reg || step_done) begin
      tick_reg <= 32'h0000_0000;
    end else begin
      tick_reg <= tick_reg + 32'h0000_0001;
    end
  end

  // free-runs outside the timed states; only its value on entry matters
  always_ff @(posedge clk) begin
    if (rst || state_next != state_reg) begin
      steps_reg <= 7'h00;
    end else if (step_done) begin
      steps_reg <= steps_reg + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge clk) begin
    if (rst) begin
      brake_release_out <= 1'b0;
    end else begin
      brake_release_out <= release_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      motor_power_on <= 1'b0;
    end else begin
      motor_power_on <= power_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // terminal allocation, taken once so changes wait for restart

  always_ff @(posedge clk) begin
    if (rst) begin
      alloc_reg       <= `HBS_ALLOC_NONE;
      alloc_taken_reg <= 1'b0;
    end else if (!alloc_taken_reg) begin
      alloc_reg       <= output_alloc_setting;
      alloc_taken_reg <= 1'b1;
    end
  end

  // sharing with other functions is the integrator's concern; it is ORed
  hbs_out_map #(
    .NUM_TERMS (NUM_TERMS)
  ) u_map (
    .clk            (clk),
    .rst            (rst),
    .brake_release  (release_next),
    .alloc          (alloc_reg),
    .other_func_out (other_func_out),
    .term_out       (term_out)
  );

endmodule : hbs_sequencer
